// ### include/cscfl_pkg.sv
package cscfl_pkg;

	////////////////////////////////////////////////////////////////////////
	// Bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;

	// Register byte offsets
	localparam logic [11:0] IRQ_EN_SET_OFS = 12'h000;
	localparam logic [11:0] IRQ_EN_CLR_OFS = 12'h004;
	localparam logic [11:0] IRQ_FLAG_OFS = 12'h008;
	localparam logic [11:0] FLL_CTRL_OFS = 12'h024;
	localparam logic [11:0] FLL_VALUE_OFS = 12'h028;
	localparam logic [11:0] FLL_MUL_OFS = 12'h02c;

	////////////////////////////////////////////////////////////////////////
	// Interrupt source bits
	localparam int IRQ_W = 18;
	localparam int PLL_LOCK_TIMEOUT_BIT = 17;
	localparam int PLL_LOCK_LOST_BIT = 16;
	localparam int PLL_LOCK_GAINED_BIT = 15;
	localparam int BROWNOUT_SYNC_READY_BIT = 11;
	localparam logic [17:0] IRQ_IMPL_MASK = 18'h38fff;
	localparam logic [17:0] IRQ_RESET = 18'h00000;

	////////////////////////////////////////////////////////////////////////
	// Loop control and value fields
	localparam int LOOP_CLOSED_BIT = 0;
	localparam int DIFF_LSB = 16;
	localparam int DIFF_W = 16;
	localparam int COARSE_LSB = 10;
	localparam int COARSE_W = 6;
	localparam int FINE_LSB = 0;
	localparam int FINE_W = 10;

	// Multiplier register fields
	localparam int COARSE_MAX_STEP_LSB = 26;
	localparam int FINE_MAX_STEP_LSB = 16;
	localparam int MUL_LSB = 0;
	localparam int MUL_W = 16;
	localparam logic [31:0] FLL_MUL_RESET = 32'h00000000;
	localparam logic [5:0] COARSE_RESET = 6'h00;
	localparam logic [9:0] FINE_RESET = 10'h000;

	// Difference scaling while coarse stepping
	localparam int COARSE_SHIFT = 4;

	// Loop phases
	typedef enum logic [0:0] {
		CSCFL_COARSE,
		CSCFL_FINE
	} cscfl_phase_type;

	// Smaller of two unsigned 16-bit values
	function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
		min16 = (a < b) ? a : b;
	endfunction : min16

	// Magnitude of a signed 16-bit difference
	function automatic logic [15:0] mag16(input logic [15:0] d);
		mag16 = d[15] ? 16'((~d) + 16'h0001) : d;
	endfunction : mag16

endpackage : cscfl_pkg

// ### core/cscfl_ratio_counter.sv
`timescale 1ns/1ps
`default_nettype none

module cscfl_ratio_counter #(
	parameter int CNT_W = 16
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Ticks
	input wire logic enable_in,
	input wire logic out_tick_in,
	input wire logic ref_tick_in,
	// Result
	output logic [CNT_W-1:0] count_out,
	output logic done_out
);

	logic [CNT_W-1:0] acc_r;
	wire logic acc_full = &acc_r;
	wire logic [CNT_W-1:0] acc_inc = acc_full ? acc_r : CNT_W'(acc_r + 1'b1);
	wire logic [CNT_W-1:0] first_cnt = out_tick_in ? CNT_W'(1) : CNT_W'(0);

	////////////////////////////////////////////////////////////////////////
	// Count output cycles, saturating so a runaway oscillator reads large
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			acc_r <= '0;
			count_out <= '0;
			done_out <= 1'b0;
		end else begin
			done_out <= enable_in & ref_tick_in;
			if (!enable_in) begin
				acc_r <= '0;
			end else if (ref_tick_in) begin
				count_out <= acc_r;
				acc_r <= first_cnt; // Tick on the boundary opens next period
			end else if (out_tick_in) begin
				acc_r <= acc_inc;
			end
		end
	end

endmodule : cscfl_ratio_counter

`default_nettype wire

// ### core/cscfl_trim_limiter.sv
`timescale 1ns/1ps
`default_nettype none

module cscfl_trim_limiter #(
	parameter int W = 6,
	parameter int SHIFT = 0
) (
	// Present trim and loop error
	input wire logic [W-1:0] cur_in,
	input wire logic [15:0] diff_in,
	input wire logic [W-1:0] max_step_in,
	// Proposed trim
	output logic [W-1:0] next_out,
	output logic moving_out
);

	// Error scaled, then never more than the allowed step
	wire logic [15:0] want = 16'(cscfl_pkg::mag16(diff_in) >> SHIFT);
	wire logic [15:0] step = cscfl_pkg::min16(want, 16'(max_step_in));
	wire logic [16:0] up = 17'(cur_in) + 17'(step);
	wire logic [16:0] top = 17'((17'h1 << W) - 17'h1);
	wire logic [16:0] up_sat = (up > top) ? top : up;
	wire logic [16:0] dn_sat = (17'(step) > 17'(cur_in)) ? 17'h0 : 17'(cur_in) - 17'(step);

	// Positive difference means too few cycles: raise the trim
	assign next_out = diff_in[15] ? dn_sat[W-1:0] : up_sat[W-1:0];
	assign moving_out = (step != 16'h0000);

endmodule : cscfl_trim_limiter

`default_nettype wire

// ### core/cscfl_top.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Writing one to bit 17 of the enable-set register sets the lock-timeout enable; zero does nothing.
// - Writing one to bit 16 sets the lock-lost enable; a zero there changes nothing.
// - Writing one to bit 15 sets the lock-gained enable; a zero there is ignored.
// - Writing one to bit 11 sets the brown-out sync-ready enable; a zero there has no effect.
// - A set flag whose enable is one raises the interrupt request; with the enable at zero it does not.
// - The loop runs closed while the loop-mode bit is one and open otherwise.
// - In closed loop the difference field holds the target count minus the measured count.
// - In open loop the difference field is no longer updated and must be treated as invalid.
// - Coarse trim is software-writable in open loop and loop-driven, read-only, in closed loop.
// - Fine trim is software-writable in open loop and loop-driven, read-only, in closed loop.
// - A closed-loop coarse change never exceeds the coarse maximum step.
// - A closed-loop fine change never exceeds the fine maximum step.
module cscfl_top #(
	parameter int CNT_W = 16
) (
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic RST_IN,
	// APB slave
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [11:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	// Clock source events, one-cycle pulses
	input wire logic [17:0] EVENT_IN,
	// Loop measurement ticks
	input wire logic FLL_OUT_TICK_IN,
	input wire logic FLL_REF_TICK_IN,
	// Outputs to the clock unit
	output logic IRQ_OUT,
	output logic LOOP_CLOSED_OUT,
	output logic [5:0] COARSE_TRIM_OUT,
	output logic [9:0] FINE_TRIM_OUT
);

	////////////////////////////////////////////////////////////////////////
	// State
	logic [17:0] irq_en_r;
	logic [17:0] irq_en_nxt;
	logic [17:0] irq_flag_r;
	logic [17:0] irq_flag_nxt;
	logic loop_closed_select_r;
	logic [15:0] diff_r;
	logic [5:0] coarse_r;
	logic [5:0] coarse_nxt;
	logic [9:0] fine_r;
	logic [9:0] fine_nxt;
	logic [31:0] mul_r;
	cscfl_pkg::cscfl_phase_type phase_r;
	cscfl_pkg::cscfl_phase_type phase_nxt;

	////////////////////////////////////////////////////////////////////////
	// APB decode; answers in the first access-phase cycle, no wait states
	wire logic setup_ph = PSEL_IN & ~PENABLE_IN;
	wire logic access_done = PSEL_IN & PENABLE_IN & PREADY_OUT;
	wire logic wr_done = access_done & PWRITE_IN & ~PSLVERR_OUT;

	wire logic hit_en_set = (PADDR_IN == cscfl_pkg::IRQ_EN_SET_OFS);
	wire logic hit_en_clr = (PADDR_IN == cscfl_pkg::IRQ_EN_CLR_OFS);
	wire logic hit_flag = (PADDR_IN == cscfl_pkg::IRQ_FLAG_OFS);
	wire logic hit_ctrl = (PADDR_IN == cscfl_pkg::FLL_CTRL_OFS);
	wire logic hit_value = (PADDR_IN == cscfl_pkg::FLL_VALUE_OFS);
	wire logic hit_mul = (PADDR_IN == cscfl_pkg::FLL_MUL_OFS);
	wire logic hit_any = hit_en_set | hit_en_clr | hit_flag | hit_ctrl | hit_value | hit_mul;

	wire logic wr_en_set = wr_done & hit_en_set;
	wire logic wr_en_clr = wr_done & hit_en_clr;
	wire logic wr_flag = wr_done & hit_flag;
	wire logic wr_ctrl = wr_done & hit_ctrl;
	wire logic wr_value = wr_done & hit_value;
	wire logic wr_mul = wr_done & hit_mul;

	////////////////////////////////////////////////////////////////////////
	// Multiplier register fields
	wire logic [5:0] coarse_max_step = mul_r[cscfl_pkg::COARSE_MAX_STEP_LSB +: cscfl_pkg::COARSE_W];
	wire logic [9:0] fine_max_step = mul_r[cscfl_pkg::FINE_MAX_STEP_LSB +: cscfl_pkg::FINE_W];
	wire logic [15:0] ratio_target = mul_r[cscfl_pkg::MUL_LSB +: cscfl_pkg::MUL_W];

	// Software view of each register
	wire logic [31:0] en_view = {14'h0000, irq_en_r};
	wire logic [31:0] flag_view = {14'h0000, irq_flag_r};
	wire logic [31:0] ctrl_view = {31'h00000000, loop_closed_select_r};
	wire logic [31:0] value_view = {diff_r, coarse_r, fine_r};

	wire logic [31:0] rd_mux =
		(hit_en_set | hit_en_clr) ? en_view :
		hit_flag ? flag_view :
		hit_ctrl ? ctrl_view :
		hit_value ? value_view :
		hit_mul ? mul_r : 32'h00000000;

	////////////////////////////////////////////////////////////////////////
	// Bus answer registers
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			PREADY_OUT <= 1'b0;
			PSLVERR_OUT <= 1'b0;
			PRDATA_OUT <= 32'h00000000;
		end else begin
			PREADY_OUT <= setup_ph;
			PSLVERR_OUT <= setup_ph & ~hit_any; // Unmapped address errors
			if (setup_ph) begin
				PRDATA_OUT <= PWRITE_IN ? 32'h00000000 : rd_mux;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt enables: set register only adds, clear register only removes
	wire logic [17:0] wdat_irq = PWDATA_IN[17:0] & cscfl_pkg::IRQ_IMPL_MASK;
	wire logic [17:0] en_set_bits = wr_en_set ? wdat_irq : 18'h00000;
	wire logic [17:0] en_clr_bits = wr_en_clr ? wdat_irq : 18'h00000;

	assign irq_en_nxt = (irq_en_r & ~en_clr_bits) | en_set_bits;

	// Flags: an event in the clearing cycle survives the clear
	wire logic [17:0] flag_clr_bits = wr_flag ? wdat_irq : 18'h00000;
	wire logic [17:0] flag_set_bits = EVENT_IN & cscfl_pkg::IRQ_IMPL_MASK;

	assign irq_flag_nxt = (irq_flag_r & ~flag_clr_bits) | flag_set_bits;

	// Request whenever an enabled flag is pending
	wire logic irq_req = |(irq_flag_nxt & irq_en_nxt);

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			irq_en_r <= cscfl_pkg::IRQ_RESET;
			irq_flag_r <= cscfl_pkg::IRQ_RESET;
			IRQ_OUT <= 1'b0;
		end else begin
			irq_en_r <= irq_en_nxt;
			irq_flag_r <= irq_flag_nxt;
			IRQ_OUT <= irq_req;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Loop mode and multiplier
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			loop_closed_select_r <= 1'b0;
			mul_r <= cscfl_pkg::FLL_MUL_RESET;
			LOOP_CLOSED_OUT <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				loop_closed_select_r <= PWDATA_IN[cscfl_pkg::LOOP_CLOSED_BIT];
				LOOP_CLOSED_OUT <= PWDATA_IN[cscfl_pkg::LOOP_CLOSED_BIT];
			end
			if (wr_mul) begin
				mul_r <= PWDATA_IN;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Cycle measurement, active only in closed loop
	logic [15:0] meas_count;
	logic meas_done;

	cscfl_ratio_counter #(
		.CNT_W(CNT_W)
	) u_counter (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.enable_in(loop_closed_select_r),
		.out_tick_in(FLL_OUT_TICK_IN),
		.ref_tick_in(FLL_REF_TICK_IN),
		.count_out(meas_count),
		.done_out(meas_done)
	);

	// Target minus measured, two's complement
	wire logic [15:0] new_diff = 16'(ratio_target - meas_count);

	////////////////////////////////////////////////////////////////////////
	// Step proposals, each bounded by its maximum step
	logic [5:0] coarse_prop;
	logic coarse_moving;
	logic [9:0] fine_prop;
	logic fine_moving;

	cscfl_trim_limiter #(
		.W(cscfl_pkg::COARSE_W),
		.SHIFT(cscfl_pkg::COARSE_SHIFT)
	) u_coarse_lim (
		.cur_in(coarse_r),
		.diff_in(new_diff),
		.max_step_in(coarse_max_step),
		.next_out(coarse_prop),
		.moving_out(coarse_moving)
	);

	cscfl_trim_limiter #(
		.W(cscfl_pkg::FINE_W),
		.SHIFT(0)
	) u_fine_lim (
		.cur_in(fine_r),
		.diff_in(new_diff),
		.max_step_in(fine_max_step),
		.next_out(fine_prop),
		.moving_out(fine_moving)
	);

	////////////////////////////////////////////////////////////////////////
	// Loop sequencer: coarse until the scaled error rounds to zero or the coarse maximum step is zero, then fine
	always_comb begin
		phase_nxt = phase_r;
		coarse_nxt = coarse_r;
		fine_nxt = fine_r;
		if (!loop_closed_select_r) begin
			// Open loop: software owns both trims; restart coarse next time
			phase_nxt = cscfl_pkg::CSCFL_COARSE;
			if (wr_value) begin
				coarse_nxt = PWDATA_IN[cscfl_pkg::COARSE_LSB +: cscfl_pkg::COARSE_W];
				fine_nxt = PWDATA_IN[cscfl_pkg::FINE_LSB +: cscfl_pkg::FINE_W];
			end
		end else if (meas_done) begin
			case (phase_r)
				cscfl_pkg::CSCFL_COARSE: begin
					if (coarse_moving) begin
						coarse_nxt = coarse_prop;
					end else begin
						phase_nxt = cscfl_pkg::CSCFL_FINE;
					end
				end
				cscfl_pkg::CSCFL_FINE: begin
					if (fine_moving) begin
						fine_nxt = fine_prop;
					end
				end
				default: begin
					phase_nxt = cscfl_pkg::CSCFL_COARSE;
				end
			endcase
		end
	end

	// Trim and difference registers; bus writes in closed loop are dropped
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			phase_r <= cscfl_pkg::CSCFL_COARSE;
			coarse_r <= cscfl_pkg::COARSE_RESET;
			fine_r <= cscfl_pkg::FINE_RESET;
			diff_r <= 16'h0000;
			COARSE_TRIM_OUT <= cscfl_pkg::COARSE_RESET;
			FINE_TRIM_OUT <= cscfl_pkg::FINE_RESET;
		end else begin
			phase_r <= phase_nxt;
			coarse_r <= coarse_nxt;
			fine_r <= fine_nxt;
			COARSE_TRIM_OUT <= coarse_nxt;
			FINE_TRIM_OUT <= fine_nxt;
			// Holds its last value once the loop opens
			if (loop_closed_select_r && meas_done) begin
				diff_r <= new_diff;
			end
		end
	end

endmodule : cscfl_top

`default_nettype wire

// ### tb/cscfl_assertions.sv
`timescale 1ns/1ps
`default_nettype none

module cscfl_assertions (
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic RST_IN,
	// Bus, events and ticks
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [11:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	input wire logic PREADY_OUT,
	input wire logic [17:0] EVENT_IN,
	input wire logic FLL_REF_TICK_IN,
	// Block outputs
	input wire logic IRQ_OUT,
	input wire logic LOOP_CLOSED_OUT,
	input wire logic [5:0] COARSE_TRIM_OUT,
	input wire logic [9:0] FINE_TRIM_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);

	////////////////////////////////////////////////////////////////////////
	// Completed writes, decoded by offset
	wire wr_done = PSEL_IN && PENABLE_IN && PWRITE_IN && PREADY_OUT;
	wire wr_ctrl = wr_done && (PADDR_IN == cscfl_pkg::FLL_CTRL_OFS);
	wire wr_val = wr_done && (PADDR_IN == cscfl_pkg::FLL_VALUE_OFS);
	wire wr_mul = wr_done && (PADDR_IN == cscfl_pkg::FLL_MUL_OFS);
	wire any_ev = |EVENT_IN;

	// Shadow of the step limits; a step uses the value held before it
	logic [5:0] cs_r;
	logic [9:0] fs_r;
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			cs_r <= 6'h00;
			fs_r <= 10'h000;
		end else if (wr_mul) begin
			cs_r <= PWDATA_IN[31:26];
			fs_r <= PWDATA_IN[25:16];
		end
	end

	// Unsigned distance between two trim values
	function automatic int trim_gap(input int a, input int b);
		return (a > b) ? a - b : b - a;
	endfunction : trim_gap

	////////////////////////////////////////////////////////////////////////
	a_irq_rise: assert property ($rose(IRQ_OUT) |-> $past(any_ev) || $past(wr_done))
		else $error("interrupt rose with no event or write");
	a_irq_fall: assert property ($fell(IRQ_OUT) |-> $past(wr_done))
		else $error("interrupt fell with no write");
	a_mode_set: assert property (wr_ctrl |=> LOOP_CLOSED_OUT == $past(PWDATA_IN[0]))
		else $error("loop mode does not follow control write");
	a_mode_hold: assert property (!wr_ctrl |=> $stable(LOOP_CLOSED_OUT))
		else $error("loop mode changed without control write");
	a_trim_open_wr: assert property (wr_val && !LOOP_CLOSED_OUT |=>
		{COARSE_TRIM_OUT, FINE_TRIM_OUT} == $past(PWDATA_IN[15:0]))
		else $error("open loop trim write not taken");
	a_trim_closed_ro: assert property (LOOP_CLOSED_OUT && $past(LOOP_CLOSED_OUT) &&
		!$past(FLL_REF_TICK_IN, 2) |-> $stable({COARSE_TRIM_OUT, FINE_TRIM_OUT}))
		else $error("closed loop trim moved without reference tick");
	a_coarse_step: assert property (LOOP_CLOSED_OUT && $past(LOOP_CLOSED_OUT) |->
		trim_gap(COARSE_TRIM_OUT, $past(COARSE_TRIM_OUT)) <= $past(cs_r))
		else $error("coarse step above its limit");
	a_fine_step: assert property (LOOP_CLOSED_OUT && $past(LOOP_CLOSED_OUT) |->
		trim_gap(FINE_TRIM_OUT, $past(FINE_TRIM_OUT)) <= $past(fs_r))
		else $error("fine step above its limit");
	a_one_trim: assert property (LOOP_CLOSED_OUT && $past(LOOP_CLOSED_OUT) |->
		!($changed(COARSE_TRIM_OUT) && $changed(FINE_TRIM_OUT)))
		else $error("coarse and fine moved together");

	// Main scenarios reached
	c_closed: cover property ($rose(LOOP_CLOSED_OUT));
	c_irq: cover property ($rose(IRQ_OUT));
	c_coarse: cover property (LOOP_CLOSED_OUT && $changed(COARSE_TRIM_OUT));
	c_fine: cover property (LOOP_CLOSED_OUT && $changed(FINE_TRIM_OUT));
endmodule : cscfl_assertions

bind cscfl_top cscfl_assertions cscfl_assertions_i (
	.CLK_IN(CLK_IN), .RST_IN(RST_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
	.PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
	.PREADY_OUT(PREADY_OUT), .EVENT_IN(EVENT_IN), .FLL_REF_TICK_IN(FLL_REF_TICK_IN),
	.IRQ_OUT(IRQ_OUT), .LOOP_CLOSED_OUT(LOOP_CLOSED_OUT),
	.COARSE_TRIM_OUT(COARSE_TRIM_OUT), .FINE_TRIM_OUT(FINE_TRIM_OUT));

`default_nettype wire

// ### tb/cscfl_tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
	// Stimulus and observed outputs
	logic clk = 1'b0;
	logic rst, psel, pen, pwr, ot, rf, pready, pslverr, irq, closed;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, acc, v;
	logic [17:0] ev;
	logic [5:0] coarse;
	logic [9:0] fine;
	logic [15:0] t;
	logic [64:0] e;
	logic [64:0] exp_q[$];
	int bits[4] = '{17, 16, 15, 11};
	int failures = 0;
	int tests_run = 0;

	cscfl_top cscfl_top_i (
		.CLK_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
		.PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
		.PSLVERR_OUT(pslverr), .EVENT_IN(ev), .FLL_OUT_TICK_IN(ot), .FLL_REF_TICK_IN(rf),
		.IRQ_OUT(irq), .LOOP_CLOSED_OUT(closed), .COARSE_TRIM_OUT(coarse),
		.FINE_TRIM_OUT(fine));

	initial begin
		forever #4 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic give_verdict;
		$display("failures=%0d tests_run=%0d", failures, tests_run);
		if (failures == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic [32:0] got, input logic [32:0] want);
		tests_run++;
		if (got !== want) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask : chk

	// Read results against the oldest note; mask hides fields left open
	// Taken at the rising edge that completes the access
	always @(posedge clk) begin
		if (pready && psel && pen && !pwr) begin
			if (exp_q.size() == 0) chk(33'h1, 33'h0);
			else begin
				e = exp_q.pop_front();
				chk({pslverr, prdata & e[64:33]}, {e[32], e[31:0] & e[64:33]});
			end
		end
	end

	// Request held until ready is seen; bounded wait
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		// Ready is judged at the rising edge, where the transfer completes
		do begin
			@(posedge clk);
			n++;
		end while (!pready && n < 20);
		if (!pready) begin
			failures++;
			give_verdict();
		end else begin
			psel <= 1'b0;
			pen <= 1'b0;
		end
	endtask : apb

	task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic er);
		exp_q.push_back({m, er, d});
		apb(1'b0, a, 32'h00000000);
	endtask : rd

	task automatic pulse(input int b);
		@(posedge clk);
		ev <= 18'h00001 << b;
		@(posedge clk);
		ev <= 18'h00000;
		@(negedge clk);
	endtask : pulse

	// Loop period of n output ticks closed by a reference tick
	task automatic per(input int n);
		repeat (n) begin
			@(posedge clk);
			ot <= 1'b1;
		end
		@(posedge clk);
		ot <= 1'b0;
		rf <= 1'b1;
		@(posedge clk);
		rf <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : per

	////////////////////////////////////////////////////////////////////////
	initial begin
		{psel, pen, pwr, ot, rf, rst} = 6'h01;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		ev = 18'h00000;
		acc = 32'h00000000;
		void'($urandom(61));
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(cscfl_pkg::FLL_MUL_OFS, 32'h00000000, 32'hffffffff, 1'b0);
		// Each enable sets alone; a zero write keeps it
		foreach (bits[i]) begin
			acc |= 32'h00000001 << bits[i];
			apb(1'b1, cscfl_pkg::IRQ_EN_SET_OFS, 32'h00000001 << bits[i]);
			apb(1'b1, cscfl_pkg::IRQ_EN_SET_OFS, 32'h00000000);
			rd(cscfl_pkg::IRQ_EN_SET_OFS, acc, 32'hffffffff, 1'b0);
		end
		// Only lock-gained enabled: the other source stays silent
		apb(1'b1, cscfl_pkg::IRQ_EN_CLR_OFS, 32'hffffffff);
		apb(1'b1, cscfl_pkg::IRQ_EN_SET_OFS, 32'h00008000);
		pulse(16);
		chk(irq, 1'b0);
		pulse(15);
		chk(irq, 1'b1);
		apb(1'b1, cscfl_pkg::IRQ_FLAG_OFS, 32'h00008000);
		@(negedge clk);
		chk(irq, 1'b0);
		apb(1'b1, cscfl_pkg::IRQ_EN_SET_OFS, 32'h00010000);
		@(negedge clk);
		chk(irq, 1'b1);
		apb(1'b1, cscfl_pkg::IRQ_FLAG_OFS, 32'hffffffff);
		rd(12'h100, 32'h00000000, 32'hffffffff, 1'b1);
		// Open loop: trims take software values
		apb(1'b1, cscfl_pkg::FLL_VALUE_OFS, 32'h00002864);
		rd(cscfl_pkg::FLL_VALUE_OFS, 32'h00002864, 32'h0000ffff, 1'b0);
		// Closed loop ignores trim writes
		t = 16'h0028 + 16'($urandom % 8);
		apb(1'b1, cscfl_pkg::FLL_MUL_OFS, {6'h01, 10'h003, t});
		apb(1'b1, cscfl_pkg::FLL_CTRL_OFS, 32'h00000001);
		@(negedge clk);
		chk(closed, 1'b1);
		apb(1'b1, cscfl_pkg::FLL_VALUE_OFS, 32'h0000ffff);
		rd(cscfl_pkg::FLL_VALUE_OFS, 32'h00002864, 32'h0000ffff, 1'b0);
		// Large error: coarse moves by its limit of one
		per(5);
		rd(cscfl_pkg::FLL_VALUE_OFS, {t - 16'h0005, 6'h0b, 10'h064}, 32'hffffffff, 1'b0);
		// Small error: coarse holds, fine may take over
		per(int'(t) - 2);
		rd(cscfl_pkg::FLL_VALUE_OFS, {16'h0002, 6'h0b, 10'h000}, 32'hfffffc00, 1'b0);
		// Fine phase: error of seven, fine moves by its limit of three
		per(int'(t) - 7);
		rd(cscfl_pkg::FLL_VALUE_OFS, {16'h0007, 6'h0b, 10'h067}, 32'hffffffff, 1'b0);
		// Back in open loop the difference stays put
		apb(1'b1, cscfl_pkg::FLL_CTRL_OFS, 32'h00000000);
		@(negedge clk);
		chk(closed, 1'b0);
		per(7);
		v = $urandom;
		apb(1'b1, cscfl_pkg::FLL_VALUE_OFS, v);
		rd(cscfl_pkg::FLL_VALUE_OFS, {16'h0007, v[15:0]}, 32'hffffffff, 1'b0);
		chk({coarse, fine}, v[15:0]);
		give_verdict();
	end
endmodule : tb

`default_nettype wire
